// ===== inc/src_status_pkg.sv
// Package: offsets, reset values and field positions of the input status and priority slice
package src_status_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_VALID_LOWER = 8'h0E;          // Lower validity byte (not held here)
    localparam logic [7:0] ADDR_VALID_UPPER = 8'h0F;          // Upper validity byte
    localparam logic [7:0] ADDR_SE_ALARMS   = 8'h11;          // Single-ended input alarms
    localparam logic [7:0] ADDR_DIFF_ALARMS = 8'h12;          // Differential input alarms
    localparam logic [7:0] ADDR_SBY_ALARMS  = 8'h14;          // Standby input alarms
    localparam logic [7:0] ADDR_DIFF_PRIO   = 8'h0F + 8'h00;  // Unused alias guard
    localparam logic [7:0] ADDR_SE_PRIO     = 8'h19;          // Single-ended priorities

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_SE_ALARMS    = 8'h22;          // Both activity alarms set
    localparam logic [7:0] RST_DIFF_ALARMS  = 8'h22;          // Same layout as single-ended
    localparam logic [7:0] RST_SBY_ALARMS   = 8'h02;          // Lower position only
    localparam logic [7:0] RST_SE_PRIO      = 8'h32;          // Upper rank 3, lower rank 2
    localparam logic [7:0] RST_VALID_UPPER  = 8'h00;          // Standby invalid at reset

    // ************************************************************
    // Field positions within an alarm register
    // ************************************************************
    localparam int BIT_UP_ACT   = 5;                          // Upper input activity alarm
    localparam int BIT_UP_LOCK  = 4;                          // Upper input phase-lock alarm
    localparam int BIT_LO_ACT   = 1;                          // Lower input activity alarm
    localparam int BIT_LO_LOCK  = 0;                          // Lower input phase-lock alarm
    localparam int BIT_SBY_VAL  = 0;                          // Standby validity bit
    localparam logic [7:0] ALARM_MASK = 8'h33;                // Bits that exist in alarm regs
    localparam logic [7:0] SBY_MASK   = 8'h03;                // Bits that exist for standby
    localparam logic [3:0] RANK_OFF   = 4'h0;                 // Rank that removes an input

endpackage : src_status_pkg

// ===== hw/alarm_status_cell.sv
// Module: one input alarm status register with monitor update and test-mode write
`timescale 1ns/1ps
module alarm_status_cell #(
    parameter logic [7:0] RST_VALUE = 8'h00  // Value after reset, already masked
) (
    input  wire logic       clk_sys,    // System clock
    input  wire logic       rst_n,      // Synchronised reset, active low
    input  wire logic [7:0] bit_mask,   // Bits that exist
    input  wire logic       test_mode,  // Test mode enables host writes
    input  wire logic       wr_en,      // Host write to this register
    input  wire logic [7:0] wr_data,    // Host write data
    input  wire logic       up_act,     // Upper input no-activity alarm
    input  wire logic       up_lock,    // Upper input phase-lock alarm
    input  wire logic       lo_act,     // Lower input no-activity alarm
    input  wire logic       lo_lock,    // Lower input phase-lock alarm
    output logic      [7:0] alarm_reg   // Register contents
);

    logic [7:0] mon_value; // Monitor-driven value

    // ************************************************************
    // Monitor image
    // ************************************************************
    always_comb begin
        mon_value = 8'h00;
        mon_value[src_status_pkg::BIT_UP_ACT]  = up_act;   // [RL2]
        mon_value[src_status_pkg::BIT_LO_ACT]  = lo_act;   // [RL2]
        mon_value[src_status_pkg::BIT_UP_LOCK] = up_lock;  // [RL3]
        mon_value[src_status_pkg::BIT_LO_LOCK] = lo_lock;  // [RL3]
    end

    // ************************************************************
    // Register update
    // ************************************************************
    // Monitors own the register; a host write lands only in test mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // Idle-input image, so validity cannot flash high after reset
            alarm_reg <= RST_VALUE;
        end else if (test_mode && wr_en) begin
            alarm_reg <= wr_data & bit_mask;              // [RL6]
        end else begin
            alarm_reg <= mon_value & bit_mask;
        end
    end

    chk_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL6]
        (wr_en && !test_mode) |=> alarm_reg == ($past(mon_value) & bit_mask))
        else $error("alarm register took a write outside test mode");

    chk_activity_bits: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL2]
        !(test_mode && wr_en) |=> alarm_reg[src_status_pkg::BIT_LO_ACT]
            == ($past(lo_act) & bit_mask[src_status_pkg::BIT_LO_ACT]))
        else $error("activity bit does not follow monitor");

    chk_lock_bits: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL3]
        !(test_mode && wr_en) |=> alarm_reg[src_status_pkg::BIT_LO_LOCK] == $past(lo_lock))
        else $error("phase-lock bit does not follow detector");

endmodule : alarm_status_cell

// ===== hw/input_source_status_priority.sv
// Module: input status, validity and single-ended priority register slice
`timescale 1ns/1ps
// Overview of operation
// RL1 - Upper validity bit 0 shows standby valid
// RL2 - Bits 5,1 show no-activity alarms
// RL3 - Bits 4,0 show phase-lock alarms
// RL4 - Offset 0x12 reports differential inputs
// RL5 - Offset 0x14 reports standby, lower bits
// RL6 - Alarm registers writable only in test
// RL7 - Four-bit rank; zero removes input
// RL8 - Nonzero differential rank zeroes single-ended rank
// RL9 - Validity clears on either alarm
module input_source_status_priority (
    input  wire logic       clk_sys,        // System clock, 100 MHz
    input  wire logic       rstn,           // Asynchronous reset, active low
    input  wire logic [7:0] reg_addr,       // Register address
    input  wire logic       reg_wr,         // Write strobe
    input  wire logic       reg_rd,         // Read strobe
    input  wire logic [7:0] reg_wdata,      // Write data
    output logic      [7:0] reg_rdata,      // Read data
    input  wire logic       test_mode,      // Device test mode
    input  wire logic [1:0] se_act_alarm,   // Single-ended no-activity, [1]=upper
    input  wire logic [1:0] se_lock_alarm,  // Single-ended phase-lock, [1]=upper
    input  wire logic [1:0] diff_act_alarm, // Differential no-activity, [1]=upper
    input  wire logic [1:0] diff_lock_alarm,// Differential phase-lock, [1]=upper
    input  wire logic       sby_act_alarm,  // Standby no-activity alarm
    input  wire logic       sby_lock_alarm, // Standby phase-lock alarm
    input  wire logic [1:0] diff_rank_set,  // Differential rank written nonzero, [1]=upper
    output logic      [3:0] lower_single_ended_rank, // Lower single-ended rank
    output logic      [3:0] upper_single_ended_rank, // Upper single-ended rank
    output logic      [1:0] se_selectable,  // Rank nonzero, [1]=upper
    output logic            standby_valid   // Standby input valid
);

    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    logic rst_meta_reg; // First stage
    logic rst_n;        // Synchronised reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ************************************************************
    // Alarm status registers
    // ************************************************************
    logic [7:0] se_alarm_reg;   // Offset 0x11
    logic [7:0] diff_alarm_reg; // Offset 0x12
    logic [7:0] sby_alarm_reg;  // Offset 0x14

    alarm_status_cell #(.RST_VALUE(src_status_pkg::RST_SE_ALARMS)) u_se_alarms (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .bit_mask  (src_status_pkg::ALARM_MASK),
        .test_mode (test_mode),
        .wr_en     (reg_wr && reg_addr == src_status_pkg::ADDR_SE_ALARMS),
        .wr_data   (reg_wdata),
        .up_act    (se_act_alarm[1]),
        .up_lock   (se_lock_alarm[1]),
        .lo_act    (se_act_alarm[0]),
        .lo_lock   (se_lock_alarm[0]),
        .alarm_reg (se_alarm_reg)
    );

    // Same layout, differential pair
    alarm_status_cell #(.RST_VALUE(src_status_pkg::RST_DIFF_ALARMS)) u_diff_alarms ( // [RL4]
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .bit_mask  (src_status_pkg::ALARM_MASK),
        .test_mode (test_mode),
        .wr_en     (reg_wr && reg_addr == src_status_pkg::ADDR_DIFF_ALARMS),
        .wr_data   (reg_wdata),
        .up_act    (diff_act_alarm[1]),
        .up_lock   (diff_lock_alarm[1]),
        .lo_act    (diff_act_alarm[0]),
        .lo_lock   (diff_lock_alarm[0]),
        .alarm_reg (diff_alarm_reg)
    );

    // Standby occupies only the lower positions
    alarm_status_cell #(.RST_VALUE(src_status_pkg::RST_SBY_ALARMS)) u_sby_alarms ( // [RL5]
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .bit_mask  (src_status_pkg::SBY_MASK),
        .test_mode (test_mode),
        .wr_en     (reg_wr && reg_addr == src_status_pkg::ADDR_SBY_ALARMS),
        .wr_data   (reg_wdata),
        .up_act    (1'b0),
        .up_lock   (1'b0),
        .lo_act    (sby_act_alarm),
        .lo_lock   (sby_lock_alarm),
        .alarm_reg (sby_alarm_reg)
    );

    // ************************************************************
    // Standby validity
    // ************************************************************
    logic [7:0] valid_upper_reg; // Upper validity byte
    // Valid only while neither standby alarm is present
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            valid_upper_reg <= src_status_pkg::RST_VALID_UPPER;
        end else begin
            valid_upper_reg <= {7'b000_0000,                      // [RL1]
                !(sby_alarm_reg[src_status_pkg::BIT_LO_ACT]
                  || sby_alarm_reg[src_status_pkg::BIT_LO_LOCK])}; // [RL9]
        end
    end
    assign standby_valid = valid_upper_reg[src_status_pkg::BIT_SBY_VAL];

    // ************************************************************
    // Single-ended priorities
    // ************************************************************
    logic [7:0] se_prio_reg; // Offset 0x19
    logic       prio_wr;     // Host write to priority register
    assign prio_wr = reg_wr && reg_addr == src_status_pkg::ADDR_SE_PRIO;

    // Differential enable overrides the matching rank nibble of a host write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            se_prio_reg <= src_status_pkg::RST_SE_PRIO;
        end else begin
            if (prio_wr) begin
                se_prio_reg <= reg_wdata;                         // [RL7]
            end
            if (diff_rank_set[0]) begin
                se_prio_reg[3:0] <= src_status_pkg::RANK_OFF;     // [RL8]
            end
            if (diff_rank_set[1]) begin
                se_prio_reg[7:4] <= src_status_pkg::RANK_OFF;     // [RL8]
            end
        end
    end

    assign lower_single_ended_rank = se_prio_reg[3:0];
    assign upper_single_ended_rank = se_prio_reg[7:4];
    // Zero rank removes the input from automatic selection
    assign se_selectable = {upper_single_ended_rank != src_status_pkg::RANK_OFF,
                            lower_single_ended_rank != src_status_pkg::RANK_OFF}; // [RL7]

    // ************************************************************
    // Read decode
    // ************************************************************
    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == src_status_pkg::ADDR_VALID_UPPER) begin
                reg_rdata <= valid_upper_reg;
            end else if (reg_addr == src_status_pkg::ADDR_SE_ALARMS) begin
                reg_rdata <= se_alarm_reg;
            end else if (reg_addr == src_status_pkg::ADDR_DIFF_ALARMS) begin
                reg_rdata <= diff_alarm_reg;
            end else if (reg_addr == src_status_pkg::ADDR_SBY_ALARMS) begin
                reg_rdata <= sby_alarm_reg;
            end else if (reg_addr == src_status_pkg::ADDR_SE_PRIO) begin
                reg_rdata <= se_prio_reg;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence sby_alarm_seen;
        sby_alarm_reg[src_status_pkg::BIT_LO_ACT] || sby_alarm_reg[src_status_pkg::BIT_LO_LOCK];
    endsequence

    chk_valid_clears: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL9]
        sby_alarm_seen |=> !standby_valid)
        else $error("standby valid while alarm present");

    chk_valid_upper_bits: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL1]
        valid_upper_reg[7:1] == 7'b000_0000)
        else $error("unused validity bits not zero");

    chk_sby_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL5]
        sby_alarm_reg[7:2] == 6'b00_0000)
        else $error("standby alarm register upper bits set");

    chk_diff_follows: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL4]
        !test_mode ##1 1 |-> diff_alarm_reg[src_status_pkg::BIT_UP_ACT]
            == $past(diff_act_alarm[1]))
        else $error("differential alarm register does not follow monitor");

    chk_rank_forced: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL8]
        diff_rank_set[0] |=> lower_single_ended_rank == src_status_pkg::RANK_OFF)
        else $error("single-ended rank not forced off");

    chk_rank_written: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
        (prio_wr && diff_rank_set == 2'b00) |=> se_prio_reg == $past(reg_wdata))
        else $error("priority write not stored");

    chk_selectable: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
        se_selectable[1] == (upper_single_ended_rank != 4'h0))
        else $error("selectable flag disagrees with rank");

    chk_se_write_test: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL6]
        (test_mode && reg_wr && reg_addr == src_status_pkg::ADDR_SE_ALARMS)
            |=> se_alarm_reg == ($past(reg_wdata) & src_status_pkg::ALARM_MASK))
        else $error("test-mode write to alarm register lost");

    // Validity returns one cycle after both standby alarms clear
    chk_valid_sets: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL9]
        !(sby_alarm_reg[src_status_pkg::BIT_LO_ACT]
          || sby_alarm_reg[src_status_pkg::BIT_LO_LOCK]) |=> standby_valid)
        else $error("standby not valid after alarms cleared");

    // Upper differential rank set removes the upper single-ended input
    chk_upper_rank_forced: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL8]
        diff_rank_set[1] |=> upper_single_ended_rank == src_status_pkg::RANK_OFF)
        else $error("upper single-ended rank not forced off");

    // Ranks hold when neither the host nor the differential side touches them
    chk_prio_held: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
        (!prio_wr && diff_rank_set == 2'b00) |=> $stable(se_prio_reg))
        else $error("priority register changed without a write");

endmodule : input_source_status_priority

// ===== tb/tb.sv
// Testbench: register accesses and monitor inputs of the input status and priority slice
`timescale 1ns/1ps
module tb;
    // ************************************************************
    // Signals
    // ************************************************************
    logic       clk_sys;          // System clock
    logic       rstn;             // Reset, active low
    logic [7:0] reg_addr;         // Register address
    logic       reg_wr;           // Write strobe
    logic       reg_rd;           // Read strobe
    logic [7:0] reg_wdata;        // Write data
    logic [7:0] reg_rdata;        // Read data
    logic       test_mode;        // Test mode
    logic [1:0] se_act_alarm;     // Single-ended activity alarms
    logic [1:0] se_lock_alarm;    // Single-ended lock alarms
    logic [1:0] diff_act_alarm;   // Differential activity alarms
    logic [1:0] diff_lock_alarm;  // Differential lock alarms
    logic       sby_act_alarm;    // Standby activity alarm
    logic       sby_lock_alarm;   // Standby lock alarm
    logic [1:0] diff_rank_set;    // Differential rank set nonzero
    logic [3:0] lower_single_ended_rank; // Lower rank
    logic [3:0] upper_single_ended_rank; // Upper rank
    logic [1:0] se_selectable;    // Ranks nonzero
    logic       standby_valid;    // Standby validity
    int         fail_count;       // Mismatches
    int         n_checks;         // Comparisons made

    input_source_status_priority input_source_status_priority_i (.*);

    // ************************************************************
    // Clock and watchdog
    // ************************************************************
    // Free-running 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Cut a hang well past the expected run of about 130 cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        summarize();
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    // Compare one byte-wide result
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte

    // Single write strobe
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
    endtask : write_reg

    // Read strobe, data sampled in the following cycle
    task automatic check_read(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clk_sys);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge clk_sys);
        reg_rd   = 1'b0;
        check_byte(reg_rdata, exp);
    endtask : check_read

    // Write an alarm register and read it back in the very next cycle
    task automatic poke_alarm(input logic tm, input logic [7:0] addr,
                              input logic [7:0] data, input logic [7:0] exp);
        test_mode = tm;
        write_reg(addr, data);
        test_mode = 1'b0;
        reg_rd    = 1'b1;
        @(negedge clk_sys);
        reg_rd    = 1'b0;
        check_byte(reg_rdata, exp);
    endtask : poke_alarm

    // Drive monitor inputs and let register and validity settle
    task automatic set_alarms(input logic [1:0] sa, input logic [1:0] sl, input logic [1:0] da,
                              input logic [1:0] dl, input logic ba, input logic bl);
        @(negedge clk_sys);
        {se_act_alarm, se_lock_alarm, diff_act_alarm, diff_lock_alarm} = {sa, sl, da, dl};
        {sby_act_alarm, sby_lock_alarm} = {ba, bl};
        repeat (3) @(negedge clk_sys);
    endtask : set_alarms

    // Print counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [1:0] oh;  // One-hot pair
        fail_count = 0;
        n_checks   = 0;
        rstn = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, test_mode, diff_rank_set} = '0;
        // Monitors show both activity alarms, matching the alarm image after reset
        {se_act_alarm, diff_act_alarm, sby_act_alarm} = 5'b11111;
        {se_lock_alarm, diff_lock_alarm, sby_lock_alarm} = 5'b00000;
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        // Standby must not look valid while its alarm image is loaded
        repeat (3) begin
            @(negedge clk_sys);
            check_byte({7'h00, standby_valid}, 8'h00);
        end
        // Values after reset
        check_read(src_status_pkg::ADDR_SE_PRIO, 8'h32);
        check_byte({upper_single_ended_rank, lower_single_ended_rank}, 8'h32);
        check_byte({6'h00, se_selectable}, 8'h03);
        check_read(src_status_pkg::ADDR_SE_ALARMS, 8'h22);
        check_read(src_status_pkg::ADDR_DIFF_ALARMS, 8'h22);
        check_read(src_status_pkg::ADDR_SBY_ALARMS, 8'h02);
        check_read(src_status_pkg::ADDR_VALID_UPPER, 8'h00);
        // Each alarm alone, differential pattern rotated so the two registers differ
        for (int i = 0; i < 2; i++) begin
            oh = 2'b01 << i;
            set_alarms(oh, 2'b00, 2'b00, oh, 1'b0, 1'b0);
            check_read(src_status_pkg::ADDR_SE_ALARMS, {2'h0, oh[1], 3'h0, oh[0], 1'b0});
            check_read(src_status_pkg::ADDR_DIFF_ALARMS, {3'h0, oh[1], 3'h0, oh[0]});
            set_alarms(2'b00, oh, oh, 2'b00, 1'b0, 1'b0);
            check_read(src_status_pkg::ADDR_SE_ALARMS, {3'h0, oh[1], 3'h0, oh[0]});
            check_read(src_status_pkg::ADDR_DIFF_ALARMS, {2'h0, oh[1], 3'h0, oh[0], 1'b0});
        end
        // Standby alarms and validity
        set_alarms(2'b11, 2'b11, 2'b11, 2'b11, 1'b0, 1'b0);
        check_read(src_status_pkg::ADDR_SBY_ALARMS, 8'h00);
        check_read(src_status_pkg::ADDR_VALID_UPPER, 8'h01);
        check_byte({7'h00, standby_valid}, 8'h01);
        set_alarms(2'b00, 2'b00, 2'b00, 2'b00, 1'b0, 1'b1);
        check_read(src_status_pkg::ADDR_SBY_ALARMS, 8'h01);
        check_byte({7'h00, standby_valid}, 8'h00);
        set_alarms(2'b00, 2'b00, 2'b00, 2'b00, 1'b1, 1'b0);
        check_read(src_status_pkg::ADDR_VALID_UPPER, 8'h00);
        set_alarms(2'b00, 2'b00, 2'b00, 2'b00, 1'b0, 1'b0);
        check_byte({7'h00, standby_valid}, 8'h01);
        // Read-only validity byte ignores writes; unmapped reads give zero
        write_reg(src_status_pkg::ADDR_VALID_UPPER, 8'hFE);
        check_read(src_status_pkg::ADDR_VALID_UPPER, 8'h01);
        check_read(8'h20, 8'h00);
        // Alarm registers: writes refused normally, taken in test mode
        poke_alarm(1'b0, src_status_pkg::ADDR_SE_ALARMS, 8'h11, 8'h00);
        poke_alarm(1'b1, src_status_pkg::ADDR_SE_ALARMS, 8'h11, 8'h11);
        poke_alarm(1'b1, src_status_pkg::ADDR_SBY_ALARMS, 8'h01, 8'h01);
        check_read(src_status_pkg::ADDR_SE_ALARMS, 8'h00);
        // Ranks, including the value that removes an input
        write_reg(src_status_pkg::ADDR_SE_PRIO, 8'h45);
        check_byte({upper_single_ended_rank, lower_single_ended_rank}, 8'h45);
        check_read(src_status_pkg::ADDR_SE_PRIO, 8'h45);
        write_reg(src_status_pkg::ADDR_SE_PRIO, 8'hF0);
        check_byte({6'h00, se_selectable}, 8'h02);
        write_reg(src_status_pkg::ADDR_SE_PRIO, 8'h0F);
        check_byte({6'h00, se_selectable}, 8'h01);
        write_reg(src_status_pkg::ADDR_SE_PRIO, 8'h00);
        check_byte({6'h00, se_selectable}, 8'h00);
        // Differential rank set forces the matching single-ended rank to zero
        write_reg(src_status_pkg::ADDR_SE_PRIO, 8'h77);
        for (int i = 0; i < 2; i++) begin
            @(negedge clk_sys);
            diff_rank_set = 2'b01 << i;
            @(negedge clk_sys);
            diff_rank_set = 2'b00;
            check_read(src_status_pkg::ADDR_SE_PRIO, (i == 0) ? 8'h70 : 8'h00);
            check_byte({6'h00, se_selectable}, (i == 0) ? 8'h02 : 8'h00);
        end
        // Reset in mid-run restores ranks and clears validity
        rstn = 1'b0;
        @(negedge clk_sys);
        check_byte({upper_single_ended_rank, lower_single_ended_rank}, 8'h32);
        check_byte({6'h00, se_selectable}, 8'h03);
        check_byte({7'h00, standby_valid}, 8'h00);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        check_read(src_status_pkg::ADDR_SBY_ALARMS, 8'h00);
        check_read(src_status_pkg::ADDR_VALID_UPPER, 8'h01);
        summarize();
    end
endmodule : tb
